// ---- bench/occo_src_model.sv ----
/* Timer clock sources and fault pins beside the channel.
   Assumes pulses are one core cycle; rates differ per source. */
`timescale 1ns/1ps
module occo_src_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Fault commands
    input wire logic fault_a_req_i,
    input wire logic fault_b_req_i,
    // Time base pulses
    output logic t1_o,
    output logic t2_o,
    output logic t3_o,
    output logic t5_o,
    output logic [7:0] trig_o,
    // Fault pins, driven low when quiet
    output logic fault_a_o,
    output logic fault_b_o
);
    logic [5:0] ph_q; // Phase 0..59, divisible by every rate
    // Phase counter
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ph_q <= 6'h00;
        end else begin
            ph_q <= (ph_q == 6'd59) ? 6'h00 : ph_q + 6'h01;
        end
    end
    // Rates 2,3,4,5,6; stray trigger bits tick each cycle
    always_ff @(posedge clk_i) begin
        t1_o <= (ph_q % 2) == 0;
        t2_o <= (ph_q % 3) == 0;
        t3_o <= (ph_q % 4) == 0;
        t5_o <= (ph_q % 5) == 0;
        trig_o <= 8'hef | {3'h0, (ph_q % 6) == 0, 4'h0};
        fault_a_o <= fault_a_req_i;
        fault_b_o <= fault_b_req_i;
    end
endmodule

// ---- bench/occo_top_assertions.sv ----
/* Port checker for occo_top, bound below.
   Assumes one clock domain and software-visible state only. */
`timescale 1ns/1ps
module occo_checker (
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    // Register port
    input wire logic [3:0] REG_ADDR_I,
    input wire logic [15:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [15:0] REG_RDATA_O,
    // Pins
    input wire logic CPU_IDLE_I,
    input wire logic FAULT_A_PIN_I,
    input wire logic FAULT_B_PIN_I,
    input wire logic COMPARE_OUT_O,
    input wire logic IRQ_O
);
    logic [15:0] ctrl_q; // Control bits as software wrote them
    logic [15:0] mask_q; // Interrupt mask as written
    logic pwm; // PWM mode codes 6 and 7
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);
    assign pwm = (ctrl_q[2:1] == 2'b11);
    // Shadow of the control word; hardware flags not tracked
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ctrl_q <= 16'h0000;
        end else if (REG_WR_I && REG_ADDR_I == occo_pkg::ADDR_CTRL) begin
            ctrl_q <= REG_WDATA_I & occo_pkg::CTRL_WR_MASK;
        end
    end
    // Shadow of the mask register
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            mask_q <= 16'h0000;
        end else if (REG_WR_I && REG_ADDR_I == occo_pkg::ADDR_IRQ_MASK) begin
            mask_q <= REG_WDATA_I & occo_pkg::IRQ_WR_MASK;
        end
    end
    a_rdata_idle_zero: assert property (
        !$past(REG_RD_I) |-> REG_RDATA_O == 16'h0000)
        else $error("read data not zero outside read");
    a_unused_bits_zero: assert property (
        $past(REG_RD_I) && $past(REG_ADDR_I) == occo_pkg::ADDR_CTRL
        |-> (REG_RDATA_O & 16'hc240) == 16'h0000)
        else $error("unimplemented control bit set");
    a_ctrl_read_back: assert property (
        REG_WR_I && REG_ADDR_I == occo_pkg::ADDR_CTRL ##1 !REG_WR_I ##1
        REG_RD_I && REG_ADDR_I == occo_pkg::ADDR_CTRL
        |=> (REG_RDATA_O & 16'h3d8f) == ($past(REG_WDATA_I, 3) & 16'h3d8f))
        else $error("control word not read back");
    a_mask_off_quiet: assert property (
        mask_q == 16'h0000 |-> !IRQ_O)
        else $error("interrupt with mask clear");
    a_fault_a_flag: assert property (
        (ctrl_q[7] && FAULT_A_PIN_I)[*4] ##0
        (REG_RD_I && REG_ADDR_I == occo_pkg::ADDR_CTRL) |=> REG_RDATA_O[4])
        else $error("fault A flag missing");
    a_fault_b_flag: assert property (
        (ctrl_q[8] && FAULT_B_PIN_I)[*4] ##0
        (REG_RD_I && REG_ADDR_I == occo_pkg::ADDR_CTRL) |=> REG_RDATA_O[5])
        else $error("fault B flag missing");
    a_fault_a_pwm: assert property (
        (pwm && ctrl_q[7] && FAULT_A_PIN_I)[*4] |=> !COMPARE_OUT_O)
        else $error("output high during fault");
    a_idle_hold_out: assert property (
        (ctrl_q[13] && CPU_IDLE_I && !REG_WR_I && !FAULT_A_PIN_I &&
        !FAULT_B_PIN_I)[*4] |-> $stable(COMPARE_OUT_O))
        else $error("output moved in idle stop");
endmodule

bind occo_top occo_checker u_chk (.*);

// ---- bench/tb_top.sv ----
/* Self-checking bench for occo_top with the source model.
   Assumes channel one, so trigger output bit 4 is its clock. */
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
    num_errors++; $display("mismatch t=%0t got %h exp %h", \
    $time, g, e); end end
module tb_top;
    logic clk, rst, reg_wr, reg_rd, idle, t1, t2, t3, t5;
    logic fa, fb, fa_req, fb_req, cmp_out, irq;
    logic [3:0] addr; // Register address
    logic [15:0] wdata, rdata, d, d2, w; // Bus data
    logic [7:0] trig; // Trigger outputs
    integer seed = 32'h8ec8; // Fixed seed, repeatable
    int num_errors, cmp_count, i, k;
    occo_top uut (.CORE_CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd),
        .REG_RDATA_O(rdata), .CPU_IDLE_I(idle), .TIMER_ONE_CLOCK_I(t1),
        .TIMER_TWO_CLOCK_I(t2), .TIMER_THREE_CLOCK_I(t3),
        .TIMER_FIVE_CLOCK_I(t5), .TRIG_GEN_OUTPUT_I(trig),
        .FAULT_A_PIN_I(fa), .FAULT_B_PIN_I(fb), .COMPARE_OUT_O(cmp_out),
        .IRQ_O(irq));
    occo_src_model src (.clk_i(clk), .rst_i(rst), .fault_a_req_i(fa_req),
        .fault_b_req_i(fb_req), .t1_o(t1), .t2_o(t2), .t3_o(t3),
        .t5_o(t5), .trig_o(trig), .fault_a_o(fa), .fault_b_o(fb));
    // Both tasks start and end on a rising edge
    task automatic bus_wr(input logic [3:0] a, input logic [15:0] v);
        addr <= a;
        wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        // One quiet edge, so a next write never reassigns the strobe
        @(posedge clk);
    endtask
    // Data stands only in the cycle after the strobe
    task automatic bus_rd(input logic [3:0] a, output logic [15:0] v);
        addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        v = rdata;
    endtask
    // Ticks expected in a 60 cycle window per select code
    function automatic int exp_ticks(input int code);
        case (code)
            7: return 60; // Every cycle
            5: return 10; // Trigger output, rate 6
            4: return 30;
            3: return 12;
            1: return 15;
            0: return 20;
            default: return 0; // Reserved gives no clock
        endcase
    endfunction
    // Window edges blur the count by a cycle or two
    function automatic logic near(input logic [15:0] g, input int e);
        if (e == 0) begin
            return g === 16'h0000;
        end
        return (int'(g) >= e - 1) && (int'(g) <= e + 2);
    endfunction
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("mismatch t=%0t run too long", $time);
        test_done;
    end
    initial begin
        {reg_wr, reg_rd, idle, fa_req, fb_req} = 5'h00;
        addr = 4'h0;
        wdata = 16'h0000;
        rst = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Reset values, unmapped slots included
        for (i = 0; i < 8; i++) begin
            bus_rd(i[3:0], d);
            `CHK(d, 16'h0000)
        end
        // Random control words, all ones first
        for (i = 0; i < 8; i++) begin
            w = (i == 0) ? 16'hffff : 16'($random(seed));
            bus_wr(occo_pkg::ADDR_CTRL, w);
            bus_rd(occo_pkg::ADDR_CTRL, d);
            `CHK(d, w & occo_pkg::CTRL_WR_MASK)
        end
        $display("test registers done");
        // Every documented clock select code, mode 1
        for (i = 0; i < 8; i++) begin
            if (i == 2) continue;
            bus_wr(occo_pkg::ADDR_CTRL, 16'h0000);
            bus_wr(occo_pkg::ADDR_SECONDARY, 16'hffff);
            bus_wr(occo_pkg::ADDR_CTRL, {3'h0, i[2:0], 10'h001});
            repeat (60) @(posedge clk);
            bus_rd(occo_pkg::ADDR_TIME_BASE, d);
            `CHK(near(d, exp_ticks(i)), 1'b1)
        end
        $display("test clock select done");
        // Idle stop freezes, idle run keeps counting
        bus_wr(occo_pkg::ADDR_CTRL, 16'h3c01);
        idle <= 1'b1;
        k = 4 + ($random(seed) & 7);
        bus_rd(occo_pkg::ADDR_TIME_BASE, d);
        repeat (k) @(posedge clk);
        bus_rd(occo_pkg::ADDR_TIME_BASE, d2);
        `CHK(d2, d)
        bus_wr(occo_pkg::ADDR_CTRL, 16'h1c01);
        bus_rd(occo_pkg::ADDR_TIME_BASE, d);
        repeat (k) @(posedge clk);
        bus_rd(occo_pkg::ADDR_TIME_BASE, d2);
        `CHK(near(d2 - d, k + 2), 1'b1)
        idle <= 1'b0;
        $display("test idle done");
        // Fault A enabled, B disabled, PWM mode
        bus_wr(occo_pkg::ADDR_IRQ_STATUS, 16'h0007);
        bus_wr(occo_pkg::ADDR_CTRL, 16'h1c86);
        fa_req <= 1'b1;
        fb_req <= 1'b1;
        repeat (6 + ($random(seed) & 3)) @(posedge clk);
        bus_rd(occo_pkg::ADDR_CTRL, d);
        `CHK(d[5:4], 2'b01)
        `CHK(irq, 1'b0)
        bus_wr(occo_pkg::ADDR_IRQ_MASK, 16'h0006);
        bus_rd(occo_pkg::ADDR_IRQ_STATUS, d);
        `CHK(d[2:1], 2'b01)
        `CHK(irq, 1'b1)
        fa_req <= 1'b0;
        fb_req <= 1'b0;
        repeat (4) @(posedge clk);
        // Software clears the flags, then fault B enabled
        bus_wr(occo_pkg::ADDR_CTRL, 16'h1d06);
        bus_wr(occo_pkg::ADDR_IRQ_STATUS, 16'h0007);
        bus_rd(occo_pkg::ADDR_CTRL, d);
        `CHK(d[5:4], 2'b00)
        `CHK(irq, 1'b0)
        fb_req <= 1'b1;
        repeat (6) @(posedge clk);
        bus_rd(occo_pkg::ADDR_CTRL, d);
        `CHK(d[5:4], 2'b10)
        `CHK(irq, 1'b1)
        fb_req <= 1'b0;
        $display("test faults done");
        // Compare values: held back in PWM, direct otherwise
        bus_wr(occo_pkg::ADDR_CTRL, 16'h0000);
        bus_wr(occo_pkg::ADDR_CTRL, 16'h1c06);
        bus_wr(occo_pkg::ADDR_SECONDARY, 16'h0005);
        repeat (20) @(posedge clk);
        bus_rd(occo_pkg::ADDR_TIME_BASE, d);
        `CHK(d > 16'h0005, 1'b1)
        bus_wr(occo_pkg::ADDR_CTRL, 16'h0000);
        bus_wr(occo_pkg::ADDR_CTRL, 16'h1c01);
        bus_wr(occo_pkg::ADDR_SECONDARY, 16'h0005);
        repeat (20) @(posedge clk);
        bus_rd(occo_pkg::ADDR_TIME_BASE, d);
        `CHK(d <= 16'h0005, 1'b1)
        $display("test buffering done");
        test_done;
    end
endmodule

// ---- hw/occo_pkg.sv ----
/*
 * Shared constants and types of the compare channel control block:
 * register addresses, control register layout, clock select codes,
 * operating mode codes and interrupt status layout.
 * Assumes a 16-bit register port with word addresses.
 */
// Functional notes
// - Idle-stop bit halts channel during CPU idle
// - Timer one source accepted only synchronously
// - Fault B enable gates fault B input
// - Fault A enable gates fault A input
// - Fault B flag set on fault B
// - Fault A flag set on fault A
// - Channel n takes trigger output n plus three
// - Unimplemented bits read zero, ignore writes
// - Trigger-mode bit 3, mode field bits 2-0
package occo_pkg;

    // Register word addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_PRIMARY = 4'h1;
    localparam logic [3:0] ADDR_SECONDARY = 4'h2;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h3;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
    localparam logic [3:0] ADDR_TIME_BASE = 4'h5;

    // Control register layout, msb first
    typedef struct packed {
        logic [1:0] unused_15_14;
        logic idle_stop_control;
        logic [2:0] time_base_select;
        logic unused_9;
        logic fault_b_enable;
        logic fault_a_enable;
        logic unused_6;
        logic fault_b_flag;
        logic fault_a_flag;
        logic trigger_mode_bit;
        logic [2:0] operating_mode_field;
    } occo_ctrl_s;

    // Implemented, writable control bits
    localparam logic [15:0] CTRL_WR_MASK = 16'h3DBF;
    // Value of the control register at power-on
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    // Time base select codes
    localparam logic [2:0] TSEL_PERIPH = 3'h7;
    localparam logic [2:0] TSEL_RESERVED = 3'h6;
    localparam logic [2:0] TSEL_TRIG_GEN = 3'h5;
    localparam logic [2:0] TSEL_TIMER1 = 3'h4;
    localparam logic [2:0] TSEL_TIMER5 = 3'h3;
    localparam logic [2:0] TSEL_TIMER3 = 3'h1;
    localparam logic [2:0] TSEL_TIMER2 = 3'h0;

    // Operating mode codes used by the compare logic
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_PWM_A = 3'h6;
    localparam logic [2:0] MODE_PWM_B = 3'h7;

    // Offset from channel number to its trigger output index
    localparam int TRIG_GEN_OFFSET = 3;

    // Interrupt status and mask layout
    typedef struct packed {
        logic [12:0] unused;
        logic fault_b;
        logic fault_a;
        logic match;
    } occo_irq_s;

    localparam logic [15:0] IRQ_WR_MASK = 16'h0007;
    localparam logic [15:0] IRQ_RESET = 16'h0000;
    localparam logic [15:0] VALUE_RESET = 16'h0000;

endpackage

// ---- hw/occo_top.sv ----
/*
 * Compare channel with its first control register: time base clock
 * selection, idle stop, fault inputs with sticky flags, compare
 * values with PWM-only double buffering, and an interrupt output.
 * Assumes timer and trigger ticks are one-cycle pulses on the core
 * clock, and fault pins are asynchronous and active high.
 */
`timescale 1ns/1ps
module occo_top #(
    parameter int CHANNEL_NUM = 1,
    parameter int COUNT_WIDTH = 16
) (
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    // Register port
    input wire logic [3:0] REG_ADDR_I,
    input wire logic [15:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [15:0] REG_RDATA_O,
    // CPU state
    input wire logic CPU_IDLE_I,
    // Time base sources, core clock pulses
    input wire logic TIMER_ONE_CLOCK_I,
    input wire logic TIMER_TWO_CLOCK_I,
    input wire logic TIMER_THREE_CLOCK_I,
    input wire logic TIMER_FIVE_CLOCK_I,
    input wire logic [7:0] TRIG_GEN_OUTPUT_I,
    // Fault pins, asynchronous
    input wire logic FAULT_A_PIN_I,
    input wire logic FAULT_B_PIN_I,
    // Channel outputs
    output logic COMPARE_OUT_O,
    output logic IRQ_O
);

    // Elaboration checks
    initial begin
        if (CHANNEL_NUM < 1 || CHANNEL_NUM > 4) begin
            $error("occo_top: CHANNEL_NUM must be 1 to 4");
        end
        if (COUNT_WIDTH < 1 || COUNT_WIDTH > 16) begin
            $error("occo_top: COUNT_WIDTH must be 1 to 16");
        end
        if (CHANNEL_NUM + occo_pkg::TRIG_GEN_OFFSET >=
            $bits(TRIG_GEN_OUTPUT_I)) begin
            $error("occo_top: trigger index beyond the bus");
        end
    end

    // Trigger output that feeds this channel
    localparam int TRIG_IDX = CHANNEL_NUM + occo_pkg::TRIG_GEN_OFFSET;

    // Control register and interrupt registers
    occo_pkg::occo_ctrl_s ctrl_q; // Control register
    logic [15:0] irq_status_q; // Sticky events
    logic [15:0] irq_mask_q; // Interrupt enables
    logic [15:0] rdata_q; // Read data, one cycle late
    logic [15:0] irq_status_d; // Status after this edge
    logic [15:0] irq_mask_d; // Mask after this edge
    logic irq_q; // Registered interrupt level

    // Fault pin synchronisers
    logic fault_a_meta_q; // First stage, feeds second only
    logic fault_a_sync_q;
    logic fault_b_meta_q; // First stage, feeds second only
    logic fault_b_sync_q;

    // Time base and compare state
    logic [COUNT_WIDTH-1:0] count_q; // Channel time base
    logic out_q; // Compare output level
    logic [15:0] primary_shadow;
    logic [15:0] primary_active;
    logic [15:0] secondary_shadow;
    logic [15:0] secondary_active;

    // Decoded strobes and conditions
    logic wr_ctrl;
    logic wr_primary;
    logic wr_secondary;
    logic wr_status;
    logic wr_mask;
    logic tick; // Selected time base pulse
    logic halted; // Idle stop in force
    logic mode_off; // Channel switched off
    logic running; // Mode active and not halted
    logic pwm_mode;
    logic fault_a_hit; // Enabled fault A seen
    logic fault_b_hit; // Enabled fault B seen
    logic fault_any;
    logic primary_match;
    logic period_end;
    logic live_tick; // Pulse the time base may count
    logic [15:0] ctrl_wdata; // Masked control write value
    occo_pkg::occo_ctrl_s ctrl_wr_s;
    occo_pkg::occo_irq_s irq_set_s;

    // Address decode, shared by writes
    function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
        hit = (a == b);
    endfunction

    // Time base pulse for a select code
    function automatic logic sel_tick(
        input logic [2:0] sel,
        input logic t1,
        input logic t2,
        input logic t3,
        input logic t5,
        input logic tg
    );
        case (sel)
            occo_pkg::TSEL_PERIPH: sel_tick = 1'b1;
            occo_pkg::TSEL_TRIG_GEN: sel_tick = tg;
            occo_pkg::TSEL_TIMER1: sel_tick = t1;
            occo_pkg::TSEL_TIMER5: sel_tick = t5;
            occo_pkg::TSEL_TIMER3: sel_tick = t3;
            occo_pkg::TSEL_TIMER2: sel_tick = t2;
            // Reserved and spare codes give no clock
            default: sel_tick = 1'b0;
        endcase
    endfunction

    // PWM mode decode
    function automatic logic is_pwm(input logic [2:0] m);
        is_pwm = (m == occo_pkg::MODE_PWM_A) ||
                 (m == occo_pkg::MODE_PWM_B);
    endfunction

    // Off mode decode, shared by run, count and output logic
    function automatic logic is_off(input logic [2:0] m);
        is_off = (m == occo_pkg::MODE_OFF);
    endfunction

    // Register write strobes
    assign wr_ctrl = REG_WR_I && hit(REG_ADDR_I, occo_pkg::ADDR_CTRL);
    assign wr_primary = REG_WR_I &&
                        hit(REG_ADDR_I, occo_pkg::ADDR_PRIMARY);
    assign wr_secondary = REG_WR_I &&
                          hit(REG_ADDR_I, occo_pkg::ADDR_SECONDARY);
    assign wr_status = REG_WR_I &&
                       hit(REG_ADDR_I, occo_pkg::ADDR_IRQ_STATUS);
    assign wr_mask = REG_WR_I && hit(REG_ADDR_I, occo_pkg::ADDR_IRQ_MASK);

    // Only implemented bits are kept from a write
    assign ctrl_wdata = REG_WDATA_I & occo_pkg::CTRL_WR_MASK;
    assign ctrl_wr_s = occo_pkg::occo_ctrl_s'(ctrl_wdata);

    // Clock source choice; timer one pulse is used as a core clock
    // enable, so only its synchronous form can drive the channel
    assign tick = sel_tick(ctrl_q.time_base_select,
                           TIMER_ONE_CLOCK_I,
                           TIMER_TWO_CLOCK_I,
                           TIMER_THREE_CLOCK_I,
                           TIMER_FIVE_CLOCK_I,
                           TRIG_GEN_OUTPUT_I[TRIG_IDX]);

    // Idle stop and run condition
    assign halted = ctrl_q.idle_stop_control && CPU_IDLE_I;
    assign mode_off = is_off(ctrl_q.operating_mode_field);
    assign running = !mode_off && !halted;
    assign pwm_mode = is_pwm(ctrl_q.operating_mode_field);

    // Faults count only while enabled
    assign fault_a_hit = ctrl_q.fault_a_enable && fault_a_sync_q;
    assign fault_b_hit = ctrl_q.fault_b_enable && fault_b_sync_q;
    assign fault_any = fault_a_hit || fault_b_hit;

    // Comparator events, only on a live time base pulse
    assign live_tick = running && tick;
    assign primary_match = live_tick &&
        (count_q == primary_active[COUNT_WIDTH-1:0]);
    assign period_end = live_tick &&
        (count_q == secondary_active[COUNT_WIDTH-1:0]);

    // Fault pin synchronisers
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            fault_a_meta_q <= 1'b0;
            fault_a_sync_q <= 1'b0;
            fault_b_meta_q <= 1'b0;
            fault_b_sync_q <= 1'b0;
        end else begin
            fault_a_meta_q <= FAULT_A_PIN_I;
            fault_a_sync_q <= fault_a_meta_q;
            fault_b_meta_q <= FAULT_B_PIN_I;
            fault_b_sync_q <= fault_b_meta_q;
        end
    end

    // Control register; hardware flag set wins over a software clear
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ctrl_q <= occo_pkg::occo_ctrl_s'(occo_pkg::CTRL_RESET);
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= ctrl_wr_s;
            end
            // Sticky fault flags
            if (fault_b_hit) begin
                ctrl_q.fault_b_flag <= 1'b1;
            end else if (wr_ctrl) begin
                ctrl_q.fault_b_flag <= ctrl_wr_s.fault_b_flag;
            end
            if (fault_a_hit) begin
                ctrl_q.fault_a_flag <= 1'b1;
            end else if (wr_ctrl) begin
                ctrl_q.fault_a_flag <= ctrl_wr_s.fault_a_flag;
            end
        end
    end

    // Compare value buffers
    occo_value_buf #(
        .WIDTH(16)
    ) u_primary (
        .clk_i(CORE_CLK_I),
        .rst_i(RST_I),
        .wr_i(wr_primary),
        .wdata_i(REG_WDATA_I),
        .buffered_i(pwm_mode),
        .load_i(period_end),
        .shadow_o(primary_shadow),
        .active_o(primary_active)
    );

    occo_value_buf #(
        .WIDTH(16)
    ) u_secondary (
        .clk_i(CORE_CLK_I),
        .rst_i(RST_I),
        .wr_i(wr_secondary),
        .wdata_i(REG_WDATA_I),
        .buffered_i(pwm_mode),
        .load_i(period_end),
        .shadow_o(secondary_shadow),
        .active_o(secondary_active)
    );

    // Time base counter; reserved code or halt freezes it
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            count_q <= '0;
        end else if (mode_off) begin
            // Disabled channel parks at zero
            count_q <= '0;
        end else if (period_end) begin
            // Secondary value closes the period
            count_q <= '0;
        end else if (live_tick) begin
            // No pulse arrives for the reserved code
            count_q <= count_q + 1'b1;
        end
    end

    // Compare output level
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            out_q <= 1'b0;
        end else if (mode_off) begin
            out_q <= 1'b0;
        end else if (pwm_mode) begin
            if (fault_any) begin
                // Fault forces the PWM output low
                out_q <= 1'b0;
            end else if (period_end) begin
                out_q <= 1'b1;
            end else if (primary_match) begin
                out_q <= 1'b0;
            end
        end else if (primary_match) begin
            // Other modes toggle on a match
            out_q <= !out_q;
        end
    end

    // Interrupt events; set wins over write-one-clear
    always_comb begin
        irq_set_s = occo_pkg::occo_irq_s'(occo_pkg::IRQ_RESET);
        irq_set_s.match = primary_match;
        irq_set_s.fault_a = fault_a_hit;
        irq_set_s.fault_b = fault_b_hit;
    end

    // Next status: write-one-clear first, then new events
    assign irq_status_d = ((irq_status_q &
        ~(wr_status ? REG_WDATA_I : occo_pkg::IRQ_RESET)) |
        irq_set_s) & occo_pkg::IRQ_WR_MASK;

    // Next mask, only implemented bits kept
    assign irq_mask_d = wr_mask ?
        (REG_WDATA_I & occo_pkg::IRQ_WR_MASK) : irq_mask_q;

    // Sticky status register
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            irq_status_q <= occo_pkg::IRQ_RESET;
        end else begin
            irq_status_q <= irq_status_d;
        end
    end

    // Interrupt mask
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            irq_mask_q <= occo_pkg::IRQ_RESET;
        end else begin
            irq_mask_q <= irq_mask_d;
        end
    end

    // Interrupt level from the next state, so the flop adds no lag
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_status_d & irq_mask_d);
        end
    end

    // Read data, valid the cycle after the read strobe
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rdata_q <= occo_pkg::VALUE_RESET;
        end else if (REG_RD_I) begin
            case (REG_ADDR_I)
                occo_pkg::ADDR_CTRL: rdata_q <= ctrl_q;
                occo_pkg::ADDR_PRIMARY: rdata_q <= primary_shadow;
                occo_pkg::ADDR_SECONDARY: rdata_q <= secondary_shadow;
                occo_pkg::ADDR_IRQ_STATUS: rdata_q <= irq_status_q;
                occo_pkg::ADDR_IRQ_MASK: rdata_q <= irq_mask_q;
                occo_pkg::ADDR_TIME_BASE: rdata_q <= 16'(count_q);
                // Unmapped addresses read zero
                default: rdata_q <= occo_pkg::VALUE_RESET;
            endcase
        end else begin
            rdata_q <= occo_pkg::VALUE_RESET;
        end
    end

    // Outputs
    assign REG_RDATA_O = rdata_q;
    assign COMPARE_OUT_O = out_q;
    assign IRQ_O = irq_q;

endmodule

// ---- hw/occo_value_buf.sv ----
/*
 * One compare value with a shadow copy. In buffered mode writes land
 * in the shadow and reach the active copy on a load pulse; otherwise
 * writes reach both copies at once.
 * Assumes write and load pulses come from the same clock.
 */
`timescale 1ns/1ps
module occo_value_buf #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic wr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic buffered_i,
    input wire logic load_i,
    // Values
    output logic [WIDTH-1:0] shadow_o,
    output logic [WIDTH-1:0] active_o
);

    initial begin
        if (WIDTH < 1 || WIDTH > 16) begin
            $error("occo_value_buf: WIDTH out of range");
        end
    end

    // Shadow copy, what software last wrote
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            shadow_o <= '0;
        end else if (wr_i) begin
            shadow_o <= wdata_i;
        end
    end

    // Active copy used by the comparator
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            active_o <= '0;
        end else if (wr_i && !buffered_i) begin
            // Direct write outside PWM
            active_o <= wdata_i;
        end else if (buffered_i && load_i) begin
            // Old shadow taken at period end
            active_o <= shadow_o;
        end
    end

endmodule
